/* src/cdm_pkg.sv */
// Shared constants and types of the carrier data modulator.
package cdm_pkg;

   // ==========================================================================
   // Register map (byte addresses on the 32-bit slave bus)
   localparam int          CDM_ADDR_W        = 5;
   localparam logic [4:0]  CDM_OFS_MAIN      = 5'h00;
   localparam logic [4:0]  CDM_OFS_CARRIER   = 5'h04;
   localparam logic [4:0]  CDM_OFS_DATA_SRC  = 5'h08;
   localparam logic [4:0]  CDM_OFS_HIGH_CAR  = 5'h0C;
   localparam logic [4:0]  CDM_OFS_LOW_CAR   = 5'h10;

   // ==========================================================================
   // Field positions
   localparam int          CDM_MAIN_ENABLE_BIT   = 7;
   localparam int          CDM_MAIN_OUT_BIT      = 5;
   localparam int          CDM_MAIN_OINV_BIT     = 4;
   localparam int          CDM_MAIN_SOFT_BIT     = 0;
   localparam int          CDM_CAR_HINV_BIT      = 5;
   localparam int          CDM_CAR_HSYNC_BIT     = 4;
   localparam int          CDM_CAR_LINV_BIT      = 1;
   localparam int          CDM_CAR_LSYNC_BIT     = 0;

   // ==========================================================================
   // Source select widths and codes
   localparam int          CDM_DSEL_W        = 5;
   localparam int          CDM_CSEL_W        = 4;
   localparam logic [4:0]  CDM_DSEL_PIN      = 5'h00;
   localparam logic [4:0]  CDM_DSEL_SOFT     = 5'h01;
   localparam logic [4:0]  CDM_DSEL_LAST     = 5'h13;
   localparam logic [3:0]  CDM_CSEL_PIN      = 4'h0;
   localparam logic [3:0]  CDM_CSEL_SYSCLK   = 4'h1;

   // ==========================================================================
   // Reset values
   localparam logic [4:0]  CDM_DSEL_RESET    = 5'h00;
   localparam logic [3:0]  CDM_CSEL_RESET    = 4'h0;

   // Software configuration of the mixer.
   typedef struct packed {
      logic                  mixer_enable;
      logic                  output_invert;
      logic                  soft_data_bit;
      logic                  high_carrier_invert;
      logic                  high_carrier_edge_sync;
      logic                  low_carrier_invert;
      logic                  low_carrier_edge_sync;
      logic [CDM_DSEL_W-1:0] data_source_select;
      logic [CDM_CSEL_W-1:0] high_carrier_select;
      logic [CDM_CSEL_W-1:0] low_carrier_select;
   } cdm_cfg_t;

   localparam cdm_cfg_t    CDM_CFG_RESET = '{
      mixer_enable:           1'b0,
      output_invert:          1'b0,
      soft_data_bit:          1'b0,
      high_carrier_invert:    1'b0,
      high_carrier_edge_sync: 1'b0,
      low_carrier_invert:     1'b0,
      low_carrier_edge_sync:  1'b0,
      data_source_select:     CDM_DSEL_RESET,
      high_carrier_select:    CDM_CSEL_RESET,
      low_carrier_select:     CDM_CSEL_RESET
   };

endpackage

/* src/cdm_modulator.sv */
// Carrier data modulator with its Avalon-MM register slave.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module cdm_modulator
   import cdm_pkg::*;
(
   input  wire logic                        clock,
   input  wire logic                        arst_n,
   input  wire logic [cdm_pkg::CDM_ADDR_W-1:0] avs_address,
   input  wire logic                        avs_read,
   input  wire logic                        avs_write,
   input  wire logic [31:0]                 avs_writedata,
   input  wire logic [3:0]                  avs_byteenable,
   output logic      [31:0]                 avs_readdata,
   output logic                             avs_waitrequest,
   input  wire logic                        data_pin_route,
   input  wire logic [19:2]                 data_src_in,
   input  wire logic                        carrier_pin_route_high,
   input  wire logic                        carrier_pin_route_low,
   input  wire logic [15:2]                 carrier_src_in,
   output logic                             mixed_output
);
   import cdm_pkg::*;

   // ==========================================================================
   // Register slave
   cdm_cfg_t    cfg_reg;
   cdm_cfg_t    cfg_next;
   logic        ack_reg;
   logic [31:0] readdata_reg;
   logic        out_sample_reg;
   logic        sel_high_reg;
   logic        car_h_q_reg;
   logic        car_l_q_reg;

   wire         req_w      = avs_read | avs_write;
   wire         wr_take_w  = avs_write & ack_reg & avs_byteenable[0];
   wire [7:0]   wbyte_w    = avs_writedata[7:0];
   wire         hit_main_w = avs_address == CDM_OFS_MAIN;
   wire         hit_car_w  = avs_address == CDM_OFS_CARRIER;
   wire         hit_dsrc_w = avs_address == CDM_OFS_DATA_SRC;
   wire         hit_hcar_w = avs_address == CDM_OFS_HIGH_CAR;
   wire         hit_lcar_w = avs_address == CDM_OFS_LOW_CAR;

   // One wait state: the first cycle of a request is stretched, the second is answered.
   assign avs_waitrequest = req_w & ~ack_reg;
   assign avs_readdata    = readdata_reg;

   always_comb
   begin
      cfg_next = cfg_reg;
      if (wr_take_w && hit_main_w)
      begin
         cfg_next.mixer_enable  = wbyte_w[CDM_MAIN_ENABLE_BIT];
         cfg_next.output_invert = wbyte_w[CDM_MAIN_OINV_BIT];
         cfg_next.soft_data_bit = wbyte_w[CDM_MAIN_SOFT_BIT];
      end
      if (wr_take_w && hit_car_w)
      begin
         cfg_next.high_carrier_invert    = wbyte_w[CDM_CAR_HINV_BIT];
         cfg_next.high_carrier_edge_sync = wbyte_w[CDM_CAR_HSYNC_BIT];
         cfg_next.low_carrier_invert     = wbyte_w[CDM_CAR_LINV_BIT];
         cfg_next.low_carrier_edge_sync  = wbyte_w[CDM_CAR_LSYNC_BIT];
      end
      if (wr_take_w && hit_dsrc_w)
      begin
         cfg_next.data_source_select = wbyte_w[CDM_DSEL_W-1:0];
      end
      if (wr_take_w && hit_hcar_w)
      begin
         cfg_next.high_carrier_select = wbyte_w[CDM_CSEL_W-1:0];
      end
      if (wr_take_w && hit_lcar_w)
      begin
         cfg_next.low_carrier_select = wbyte_w[CDM_CSEL_W-1:0];
      end
   end

   wire [31:0] rd_main_w = 32'({cfg_reg.mixer_enable, 1'b0, out_sample_reg,
                                cfg_reg.output_invert, 3'b000, cfg_reg.soft_data_bit});
   wire [31:0] rd_car_w  = 32'({cfg_reg.high_carrier_invert, cfg_reg.high_carrier_edge_sync,
                                2'b00, cfg_reg.low_carrier_invert, cfg_reg.low_carrier_edge_sync});
   wire [31:0] rd_mux_w  = hit_main_w ? rd_main_w :
                           hit_car_w  ? rd_car_w :
                           hit_dsrc_w ? 32'(cfg_reg.data_source_select) :
                           hit_hcar_w ? 32'(cfg_reg.high_carrier_select) :
                           hit_lcar_w ? 32'(cfg_reg.low_carrier_select) : 32'h00000000;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cfg_reg      <= CDM_CFG_RESET;
         ack_reg      <= 1'b0;
         readdata_reg <= 32'h00000000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         ack_reg <= req_w & ~ack_reg;
         if (avs_read && !ack_reg)
         begin
            readdata_reg <= rd_mux_w;
         end
      end
   end

   // ==========================================================================
   // Source selection
   wire        en_w = cfg_reg.mixer_enable;
   wire [4:0]  dsel_w = cfg_reg.data_source_select;
   wire [3:0]  hsel_w = cfg_reg.high_carrier_select;
   wire [3:0]  lsel_w = cfg_reg.low_carrier_select;

   wire        data_sel_w = (dsel_w == CDM_DSEL_PIN)  ? data_pin_route :
                            (dsel_w == CDM_DSEL_SOFT) ? cfg_reg.soft_data_bit :
                            (dsel_w <= CDM_DSEL_LAST) ? data_src_in[dsel_w] : 1'b0;
   wire        data_w     = en_w ? data_sel_w : cfg_reg.soft_data_bit;

   // The system clock feeds the mix directly so its full rate reaches the pin.
   wire        car_h_sel_w = (hsel_w == CDM_CSEL_PIN)    ? carrier_pin_route_high :
                             (hsel_w == CDM_CSEL_SYSCLK) ? clock : carrier_src_in[hsel_w];
   wire        car_l_sel_w = (lsel_w == CDM_CSEL_PIN)    ? carrier_pin_route_low :
                             (lsel_w == CDM_CSEL_SYSCLK) ? clock : carrier_src_in[lsel_w];

   wire        car_h_w = en_w & (car_h_sel_w ^ cfg_reg.high_carrier_invert);
   wire        car_l_w = en_w & (car_l_sel_w ^ cfg_reg.low_carrier_invert);

   // ==========================================================================
   // Carrier synchronisation
   // The running carrier is judged from its sampled level, so a switch may lag
   // the carrier's fall by up to one clock; carriers faster than the clock are
   // best used without synchronisation.
   wire        cur_sync_w = sel_high_reg ? cfg_reg.high_carrier_edge_sync
                                         : cfg_reg.low_carrier_edge_sync;
   wire        cur_car_q_w = sel_high_reg ? car_h_q_reg : car_l_q_reg;
   wire        hold_w = en_w & (data_w != sel_high_reg) & cur_sync_w & cur_car_q_w;
   wire        sel_high_w = hold_w ? sel_high_reg : data_w;

   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sel_high_reg   <= 1'b0;
         car_h_q_reg    <= 1'b0;
         car_l_q_reg    <= 1'b0;
         out_sample_reg <= 1'b0;
      end
      else
      begin
         sel_high_reg   <= sel_high_w;
         car_h_q_reg    <= car_h_w;
         car_l_q_reg    <= car_l_w;
         out_sample_reg <= mixed_output;
      end
   end

   // ==========================================================================
   // Mixing and output
   // The path from carrier to pin is kept free of flip-flops on purpose.
   wire        mix_w = sel_high_w ? car_h_w : car_l_w;

   assign mixed_output = en_w & (mix_w ^ cfg_reg.output_invert);

endmodule

`default_nettype wire

/* dv/cdm_src_model.sv */
// Behavioural model of the on-chip sources and pins feeding the mixer.
`timescale 1ns/1ps
`default_nettype none
module cdm_src_model
(
   input  wire logic        clock,
   input  wire logic [34:0] pattern,
   output logic             data_pin_route,
   output logic [19:2]      data_src_in,
   output logic             carrier_pin_route_high,
   output logic             carrier_pin_route_low,
   output logic [15:2]      carrier_src_in
);
   // Peripheral outputs move only on system clock edges, as real on-chip sources do.
   always_ff @(posedge clock)
      {data_pin_route, data_src_in, carrier_pin_route_high, carrier_pin_route_low, carrier_src_in} <= pattern;
endmodule
`default_nettype wire

/* dv/cdm_chk.sv */
// Concurrent checks on the modulator register bus and output.
`timescale 1ns/1ps
`default_nettype none
module cdm_chk
(
   input wire logic        clock,
   input wire logic        arst_n,
   input wire logic [4:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        mixed_output
);
   logic en_reg;
   wire  take_w = avs_write && !avs_waitrequest && avs_address == 5'h00 && avs_byteenable[0];
   // Enable is mirrored from accepted writes, since the checker cannot see the register.
   always_ff @(posedge clock or negedge arst_n)
      if (!arst_n) en_reg <= 1'b0;
      else if (take_w) en_reg <= avs_writedata[7];
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   sequence s_req_wait;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_read_done;
      avs_read && !avs_waitrequest;
   endsequence
   a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest) else $error("stall without request");
   a_wait_one: assert property (s_req_wait |=> !avs_waitrequest) else $error("not one wait state");
   a_wait_gap: assert property ((avs_read || avs_write) && !avs_waitrequest |=> !avs_read && !avs_write || avs_waitrequest)
      else $error("answer twice in a row");
   a_upper_zero: assert property (s_read_done |-> avs_readdata[31:8] == 24'h000000) else $error("upper bits set");
   a_unmapped_zero: assert property ((s_read_done and (avs_address > 5'h10)) |-> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_read_enable: assert property ((s_read_done and (avs_address == 5'h00)) |-> avs_readdata[7] == en_reg)
      else $error("enable readback");
   a_disabled_low: assert property (!en_reg |-> !mixed_output) else $error("output high while disabled");
   a_rdata_hold: assert property (!avs_read ##1 !avs_read |-> $stable(avs_readdata)) else $error("read data moved");
endmodule
bind cdm_modulator cdm_chk u_chk (.clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mixed_output(mixed_output));
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench of the carrier data modulator.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import cdm_pkg::*;
   logic        clock = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, dp, hp, lp;
   logic        avs_waitrequest, mixed_output;
   logic [4:0]  avs_address = 5'h00;
   logic [3:0]  avs_byteenable = 4'hF;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, lf = 32'h2A3E;
   logic [19:2] ds;
   logic [15:2] cs;
   logic [34:0] pattern = '0;
   logic [7:0]  main_v, car_v, dsel, hsel, lsel;
   int          err_count = 0, checked = 0, cycles = 0;
   cdm_modulator uut (.clock(clock), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .data_pin_route(dp), .data_src_in(ds),
      .carrier_pin_route_high(hp), .carrier_pin_route_low(lp), .carrier_src_in(cs), .mixed_output(mixed_output));
   cdm_src_model u_src (.clock(clock), .pattern(pattern), .data_pin_route(dp), .data_src_in(ds),
      .carrier_pin_route_high(hp), .carrier_pin_route_low(lp), .carrier_src_in(cs));
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic logic pick_c(input logic [7:0] s, input logic pin);
      pick_c = (s == 8'h00) ? pin : (s == 8'h01) ? clock : cs[s[3:0]];
   endfunction
   function automatic logic model();
      logic d, h, l;
      d = (dsel == 8'h00) ? dp : (dsel == 8'h01) ? main_v[0] : (dsel < 8'h14) ? ds[dsel[4:0]] : 1'b0;
      h = pick_c(hsel, hp) ^ car_v[5];
      l = pick_c(lsel, lp) ^ car_v[1];
      model = main_v[7] & ((d ? h : l) ^ main_v[4]);
   endfunction
   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clock); while (avs_waitrequest !== 1'b0);
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cfg();
      bus(1'b1, CDM_OFS_MAIN, main_v);
      bus(1'b1, CDM_OFS_CARRIER, car_v);
      bus(1'b1, CDM_OFS_DATA_SRC, dsel);
      bus(1'b1, CDM_OFS_HIGH_CAR, hsel);
      bus(1'b1, CDM_OFS_LOW_CAR, lsel);
   endtask
   task automatic rd_all_zero();
      for (int a = 0; a <= 20; a += 4)
      begin
         bus(1'b0, 5'(a), 8'h00);
         check(rd, 32'h0);
      end
   endtask
   task automatic cmp_out();
      repeat (2) @(posedge clock);
      #1 check(32'(mixed_output), 32'(model()));
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always #25 clock = ~clock;
   // The ceiling sits far above the roughly 1300 cycles the sequence needs.
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         close_out();
      end
   end
   initial
   begin
      repeat (5) @(posedge clock);
      arst_n <= 1'b1;
      rd_all_zero();
      for (int i = 0; i < 60; i++)
      begin
         lf = lfsr(lf);
         main_v = {1'b1, 2'b00, lf[4], 3'b000, lf[0]};
         car_v = {2'b00, lf[5], 3'b000, lf[6], 1'b0};
         dsel = {3'h0, lf[12:8]};
         hsel = {4'h0, lf[16:13]};
         lsel = {4'h0, lf[20:17]};
         cfg();
         pattern <= {lf[31:29], lfsr(lf)};
         cmp_out();
         bus(1'b0, CDM_OFS_DATA_SRC, 8'h00);
         check(rd, {24'h0, dsel});
      end
      avs_byteenable <= 4'h0;
      bus(1'b1, CDM_OFS_MAIN, 8'h00);
      avs_byteenable <= 4'hF;
      bus(1'b1, 5'h14, 8'hFF);
      cmp_out();
      main_v = 8'h10;
      bus(1'b1, CDM_OFS_MAIN, main_v);
      cmp_out();
      main_v = 8'h91;
      bus(1'b1, CDM_OFS_MAIN, main_v);
      cmp_out();
      // Each carrier pin is driven opposite to the other, so a switch that comes too early shows at once.
      pattern <= 35'h0_0000_8000;
      main_v = 8'h81;
      car_v = 8'h11;
      dsel = 8'h01;
      hsel = 8'h00;
      lsel = 8'h00;
      cfg();
      bus(1'b1, CDM_OFS_MAIN, 8'h80);
      repeat (2) @(posedge clock);
      #1 check(32'(mixed_output), 32'h1);
      pattern <= 35'h0_0000_4000;
      @(posedge clock);
      #1 check(32'(mixed_output), 32'h0);
      @(posedge clock);
      #1 check(32'(mixed_output), 32'h1);
      bus(1'b1, CDM_OFS_MAIN, 8'h81);
      repeat (2) @(posedge clock);
      #1 check(32'(mixed_output), 32'h1);
      pattern <= 35'h0_0000_8000;
      @(posedge clock);
      #1 check(32'(mixed_output), 32'h0);
      @(posedge clock);
      #1 check(32'(mixed_output), 32'h1);
      bus(1'b0, CDM_OFS_MAIN, 8'h00);
      check(rd, 32'h000000A1);
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      #1 check(32'(mixed_output), 32'h0);
      @(posedge clock);
      arst_n <= 1'b1;
      rd_all_zero();
      close_out();
   end
endmodule
`default_nettype wire
